// file: hdl/dtwp_top.sv
// Contract
// - Accumulator wraps modulo two to forty-eight.
// - Add step word every sample cycle.
// - Wrap keeps remainder, never resets.
// - Add 16-bit phase offset to output.
// - Hold 10-bit converter full-scale current word.
// - Free-run uses free-run step register.
// - Closed loop uses loop filter word.
// - Holdover uses recorded step word history.
// - Clamp frequency between 24-bit limits always.
// - Reset limits span zero to sample rate.
// - Average over millisecond timer interval, minimum one.
// - Store memoryless average into history record.
// - Strobe each interval; sets flag when unmasked.
// - Restart on switch; clear unless persistent.
// - Clear history by command or pin.
// - No history: wait interval before storing.
// - K early averages at power-of-two fractions.
// - Later averages at full even intervals.
// - Holdover uses average captured before entry.
// - No history: free-run or last word.
`timescale 1ns/1ps
`default_nettype none
`include "dtwp_consts.svh"

module dtwp_top #(
    parameter int unsigned CYCLES_PER_MS = `DTWP_MS_NS / `DTWP_CLK_PERIOD_NS
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic REG_WE,
    input wire logic [11:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    input wire dtwp_pkg::dtwp_mode_type LOOP_MODE,
    input wire logic [47:0] LOOP_STEP_WORD,
    input wire logic REF_SWITCH,
    input wire logic MFP_CLEAR_HISTORY,
    input wire logic HISTORY_IRQ_ENABLE,
    input wire logic HISTORY_FLAG_CLEAR,
    output logic HISTORY_STROBE,
    output logic HISTORY_UPDATED_FLAG,
    output logic HISTORY_VALID,
    output logic [47:0] STEP_WORD,
    output logic [47:0] ACCUMULATOR,
    output logic [15:0] PHASE_WORD,
    output logic [9:0] FULL_SCALE_CURRENT
);
    import dtwp_pkg::*;

    dtwp_state_type state_reg; // Registered state
    dtwp_state_type state_next; // Next state

    // Address falls inside a register's byte span
    function automatic logic in_rng(input logic [11:0] a, input logic [11:0] base, input logic [11:0] len);
        in_rng = (a >= base) && (a < base + len);
    endfunction : in_rng

    // Replace one byte of a multi-byte value, lowest address is LSB
    function automatic logic [47:0] put_byte(input logic [47:0] v, input logic [11:0] off, input logic [7:0] d);
        logic [47:0] t;
        t = v;
        t[{off[2:0], 3'b000} +: 8] = d;
        put_byte = t;
    endfunction : put_byte

    // Pick one byte of a multi-byte value
    function automatic logic [7:0] get_byte(input logic [47:0] v, input logic [11:0] off);
        get_byte = v[{off[2:0], 3'b000} +: 8];
    endfunction : get_byte

    // Next-state logic for the whole processor
    always_comb begin
        logic [47:0] tmp; // Byte-merge scratch
        logic [7:0] rd; // Read byte
        logic sw_clear; // Software clear command
        logic pin_rise; // Filtered pin rising edge
        logic clr; // History clear of either source
        logic tick; // One millisecond elapsed
        logic [47:0] sel; // Selected step word
        logic [47:0] clamped; // Step word after clamp
        logic [71:0] sum_new; // Sum including this sample
        logic [23:0] elp_new; // Sample count including this one
        logic [23:0] target; // Sample count of next average
        logic [24:0] trial; // Divider partial remainder
        logic ge; // Divider subtract succeeds
        tmp = 48'h000000000000;
        rd = 8'h00;
        sw_clear = 1'b0;
        pin_rise = 1'b0;
        clr = 1'b0;
        tick = 1'b0;
        sel = 48'h000000000000;
        clamped = 48'h000000000000;
        sum_new = 72'h0;
        elp_new = 24'h000000;
        target = 24'h000000;
        trial = 25'h0000000;
        ge = 1'b0;
        state_next = state_reg;
        state_next.strobe = 1'b0;

        // Byte writes into the register file
        if (REG_WE) begin
            if (in_rng(REG_ADDR, `DTWP_CUR_BASE, `DTWP_CUR_LEN)) begin
                tmp = put_byte({32'h00000000, state_reg.cur}, REG_ADDR - `DTWP_CUR_BASE, REG_WDATA);
                state_next.cur = tmp[15:0];
            end
            if (in_rng(REG_ADDR, `DTWP_FRW_BASE, `DTWP_FRW_LEN)) begin
                // Free-run word, one byte per write
                state_next.frw = put_byte(state_reg.frw, REG_ADDR - `DTWP_FRW_BASE, REG_WDATA);
            end
            if (in_rng(REG_ADDR, `DTWP_CLAMP_BASE, `DTWP_CLAMP_LEN)) begin
                // Lower limit in the low three bytes
                tmp = put_byte({state_reg.clamp_hi, state_reg.clamp_lo}, REG_ADDR - `DTWP_CLAMP_BASE, REG_WDATA);
                state_next.clamp_lo = tmp[23:0];
                state_next.clamp_hi = tmp[47:24];
            end
            if (in_rng(REG_ADDR, `DTWP_PHASE_BASE, `DTWP_PHASE_LEN)) begin
                // Open-loop phase offset word
                tmp = put_byte({32'h00000000, state_reg.phase_adj}, REG_ADDR - `DTWP_PHASE_BASE, REG_WDATA);
                state_next.phase_adj = tmp[15:0];
            end
            if (in_rng(REG_ADDR, `DTWP_TIMER_BASE, `DTWP_TIMER_LEN)) begin
                // Zero is not trapped; software must avoid it
                tmp = put_byte({24'h000000, state_reg.timer}, REG_ADDR - `DTWP_TIMER_BASE, REG_WDATA);
                state_next.timer = tmp[23:0];
            end
            if (REG_ADDR == `DTWP_HCTRL_BASE) begin
                // Whole byte kept; bits above four have no effect
                state_next.hctrl = REG_WDATA;
            end
            if (REG_ADDR == `DTWP_CMD_ADDR) begin
                sw_clear = REG_WDATA[`DTWP_CMD_CLEAR];
            end
        end

        // Registered read port, one cycle behind the address
        if (in_rng(REG_ADDR, `DTWP_CUR_BASE, `DTWP_CUR_LEN)) begin
            // Current word reads back all sixteen stored bits
            rd = get_byte({32'h00000000, state_reg.cur}, REG_ADDR - `DTWP_CUR_BASE);
        end else if (in_rng(REG_ADDR, `DTWP_FRW_BASE, `DTWP_FRW_LEN)) begin
            rd = get_byte(state_reg.frw, REG_ADDR - `DTWP_FRW_BASE);
        end else if (in_rng(REG_ADDR, `DTWP_CLAMP_BASE, `DTWP_CLAMP_LEN)) begin
            rd = get_byte({state_reg.clamp_hi, state_reg.clamp_lo}, REG_ADDR - `DTWP_CLAMP_BASE);
        end else if (in_rng(REG_ADDR, `DTWP_PHASE_BASE, `DTWP_PHASE_LEN)) begin
            rd = get_byte({32'h00000000, state_reg.phase_adj}, REG_ADDR - `DTWP_PHASE_BASE);
        end else if (in_rng(REG_ADDR, `DTWP_TIMER_BASE, `DTWP_TIMER_LEN)) begin
            rd = get_byte({24'h000000, state_reg.timer}, REG_ADDR - `DTWP_TIMER_BASE);
        end else if (REG_ADDR == `DTWP_HCTRL_BASE) begin
            rd = state_reg.hctrl;
        end else if (in_rng(REG_ADDR, `DTWP_RECORD_BASE, `DTWP_RECORD_LEN)) begin
            // Read-only; writes here are ignored
            rd = get_byte(state_reg.record, REG_ADDR - `DTWP_RECORD_BASE);
        end else begin
            // Unmapped and command addresses read zero
            rd = 8'h00;
        end
        // Registered so a read byte stands a whole cycle
        state_next.rdata = rd;

        // Three stages keep a metastable pin away from the clear
        // Pin synchroniser; first stage feeds only the second
        state_next.sync = {state_reg.sync[1:0], MFP_CLEAR_HISTORY};
        if (state_reg.sync[1] == state_reg.sync[2]) begin
            state_next.pin_level = state_reg.sync[2];
            pin_rise = state_reg.sync[2] & ~state_reg.pin_level;
        end
        clr = sw_clear | pin_rise;

        // Millisecond time base
        // Free-running from reset; first sample may come up to one ms late
        if (state_reg.ms_count >= 32'(CYCLES_PER_MS - 1)) begin
            state_next.ms_count = 32'h00000000;
            tick = 1'b1;
        end else begin
            state_next.ms_count = state_reg.ms_count + 32'h00000001;
        end

        // Sequential restoring divider, one quotient bit per cycle
        // Trades 72 cycles of latency for no wide combinational divider
        if (state_reg.div_cnt != 7'h00) begin
            trial = {state_reg.div_rem, state_reg.div_q[71]};
            ge = trial >= {1'b0, state_reg.divisor};
            state_next.div_q = {state_reg.div_q[70:0], ge};
            state_next.div_rem = ge ? 24'(trial - {1'b0, state_reg.divisor}) : trial[23:0];
            state_next.div_cnt = state_reg.div_cnt - 7'h01;
            if (state_reg.div_cnt == 7'h01) begin
                state_next.record = state_next.div_q[47:0];
                state_next.hist_valid = 1'b1;
                state_next.strobe = 1'b1;
            end
        end

        // History accumulation, paused outside closed loop
        if (clr || REF_SWITCH) begin
            state_next.sum = 72'h0;
            state_next.elapsed = 24'h000000;
            // Abort any division in flight
            state_next.div_cnt = 7'h00;
            state_next.strobe = 1'b0;
            state_next.record = state_reg.record;
            state_next.hist_valid = state_reg.hist_valid;
            state_next.stage = 3'h0;
            if (clr || !state_reg.hctrl[`DTWP_HCTRL_PERSIST]) begin
                state_next.hist_valid = 1'b0;
                state_next.record = 48'h000000000000;
                state_next.stage = state_reg.hctrl[`DTWP_HCTRL_K_MSB:`DTWP_HCTRL_K_LSB];
            end
        end else if (tick && LOOP_MODE == DTWP_CLOSED) begin
            sum_new = state_reg.sum + {24'h000000, LOOP_STEP_WORD};
            elp_new = state_reg.elapsed + 24'h000001;
            target = state_reg.timer >> state_reg.stage;
            state_next.sum = sum_new;
            state_next.elapsed = elp_new;
            // A checkpoint is skipped while the divider is busy
            // wait for checkpoint
            if (elp_new >= target && state_next.div_cnt == 7'h00) begin
                state_next.div_q = sum_new;
                state_next.div_rem = 24'h000000;
                state_next.divisor = elp_new;
                state_next.div_cnt = `DTWP_DIV_STEPS;
                if (state_reg.stage != 3'h0) begin
                    // Early average keeps accumulating
                    state_next.stage = state_reg.stage - 3'h1;
                end else begin
                    state_next.sum = 72'h0;
                    state_next.elapsed = 24'h000000;
                end
            end
        end

        // Status flag; a set in the clearing cycle wins
        if (HISTORY_FLAG_CLEAR) begin
            state_next.flag = 1'b0;
        end
        // Mask gates only the flag, never the strobe
        // flag when unmasked
        if (state_next.strobe && HISTORY_IRQ_ENABLE) begin
            state_next.flag = 1'b1;
        end

        // Holdover word latched once on entry
        // Later history updates leave a running holdover untouched
        state_next.prev_mode = LOOP_MODE;
        if (LOOP_MODE == DTWP_HOLDOVER && state_reg.prev_mode != DTWP_HOLDOVER) begin
            if (state_reg.hist_valid) begin
                state_next.hold_word = state_reg.record;
            end else if (state_reg.hctrl[`DTWP_HCTRL_FALLBACK]) begin
                state_next.hold_word = state_reg.step_word;
            end else begin
                state_next.hold_word = state_reg.frw;
            end
        end

        // Step word source selection
        case (LOOP_MODE)
            DTWP_FREE_RUN: begin
                sel = state_reg.frw;
            end
            DTWP_CLOSED: begin
                sel = LOOP_STEP_WORD;
            end
            DTWP_HOLDOVER: begin
                sel = state_next.hold_word;
            end
            default: begin
                // Unused mode code behaves as free-run
                sel = state_reg.frw;
            end
        endcase

        // Upper test first, so with crossed limits a word above the upper limit saturates high, any other goes low
        // clamp in all modes
        if (sel[47:24] > state_reg.clamp_hi) begin
            clamped = {state_reg.clamp_hi, 24'hFFFFFF};
        end else if (sel[47:24] < state_reg.clamp_lo) begin
            clamped = {state_reg.clamp_lo, 24'h000000};
        end else begin
            clamped = sel;
        end
        state_next.step_word = clamped;

        // Plain 48-bit overflow gives the modulo wrap
        // modulo wrap
        state_next.accum = state_reg.accum + state_reg.step_word;
        // Top sixteen bits only; lower bits are below phase resolution
        // phase offset added
        state_next.phase_out = state_reg.accum[47:32] + state_reg.phase_adj;
    end

    // State register; reset gives constants only
    // Asynchronous, so outputs are idle before the clock starts
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_reg <= '0;
            state_reg.clamp_lo <= `DTWP_CLAMP_LO_RST;
            state_reg.clamp_hi <= `DTWP_CLAMP_HI_RST;
            state_reg.timer <= `DTWP_TIMER_RST;
            state_reg.cur <= `DTWP_CUR_RST;
            state_reg.phase_adj <= `DTWP_PHASE_RST;
            state_reg.hctrl <= `DTWP_HCTRL_RST;
            state_reg.prev_mode <= DTWP_FREE_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from state flops
    assign REG_RDATA = state_reg.rdata;
    assign HISTORY_STROBE = state_reg.strobe;
    assign HISTORY_UPDATED_FLAG = state_reg.flag;
    assign HISTORY_VALID = state_reg.hist_valid;
    assign STEP_WORD = state_reg.step_word;
    assign ACCUMULATOR = state_reg.accum;
    assign PHASE_WORD = state_reg.phase_out;
    // Upper six bits of the current word are stored but unused
    assign FULL_SCALE_CURRENT = state_reg.cur[9:0];

endmodule : dtwp_top

`default_nettype wire

// file: hdl/dtwp_consts.svh
`ifndef DTWP_CONSTS_SVH
`define DTWP_CONSTS_SVH

// Byte addresses of each register's lowest byte, and byte counts
`define DTWP_CUR_BASE 12'h213
`define DTWP_CUR_LEN 12'h002
`define DTWP_FRW_BASE 12'h300
`define DTWP_FRW_LEN 12'h006
`define DTWP_CLAMP_BASE 12'h307
`define DTWP_CLAMP_LEN 12'h006
`define DTWP_PHASE_BASE 12'h30D
`define DTWP_PHASE_LEN 12'h002
`define DTWP_TIMER_BASE 12'h318
`define DTWP_TIMER_LEN 12'h003
`define DTWP_HCTRL_BASE 12'h31B
`define DTWP_HCTRL_LEN 12'h001
`define DTWP_CMD_ADDR 12'hA03
`define DTWP_RECORD_BASE 12'hD14
`define DTWP_RECORD_LEN 12'h006

// Field positions
`define DTWP_HCTRL_K_LSB 0
`define DTWP_HCTRL_K_MSB 2
`define DTWP_HCTRL_PERSIST 3
`define DTWP_HCTRL_FALLBACK 4
`define DTWP_CMD_CLEAR 2

// Reset values
`define DTWP_CLAMP_LO_RST 24'h000000
`define DTWP_CLAMP_HI_RST 24'hFFFFFF
`define DTWP_TIMER_RST 24'h000001
`define DTWP_CUR_RST 16'h0000
`define DTWP_PHASE_RST 16'h0000
`define DTWP_HCTRL_RST 8'h00

// Timing
`define DTWP_MS_NS 1000000
`define DTWP_CLK_PERIOD_NS 10
`define DTWP_DIV_STEPS 7'h48

`endif

// file: hdl/dtwp_pkg.sv
package dtwp_pkg;

    // Loop operating mode, supplied by the loop controller
    typedef enum logic [1:0] {
        DTWP_FREE_RUN,
        DTWP_CLOSED,
        DTWP_HOLDOVER
    } dtwp_mode_type;

    // Whole state of the processor
    typedef struct packed {
        logic [15:0] cur;
        logic [47:0] frw;
        logic [23:0] clamp_lo;
        logic [23:0] clamp_hi;
        logic [15:0] phase_adj;
        logic [23:0] timer;
        logic [7:0] hctrl;
        logic [47:0] record;
        logic hist_valid;
        logic [47:0] hold_word;
        dtwp_mode_type prev_mode;
        logic [47:0] step_word;
        logic [47:0] accum;
        logic [15:0] phase_out;
        logic [7:0] rdata;
        logic [31:0] ms_count;
        logic [23:0] elapsed;
        logic [71:0] sum;
        logic [2:0] stage;
        logic [6:0] div_cnt;
        logic [71:0] div_q;
        logic [23:0] div_rem;
        logic [23:0] divisor;
        logic strobe;
        logic flag;
        logic [2:0] sync;
        logic pin_level;
    } dtwp_state_type;

endpackage : dtwp_pkg

// file: test/dtwp_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module dtwp_top_monitor #(
    parameter int unsigned CYCLES_PER_MS = 100
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic REG_WE,
    input wire dtwp_pkg::dtwp_mode_type LOOP_MODE,
    input wire logic [47:0] LOOP_STEP_WORD,
    input wire logic HISTORY_IRQ_ENABLE,
    input wire logic HISTORY_STROBE,
    input wire logic HISTORY_UPDATED_FLAG,
    input wire logic HISTORY_VALID,
    input wire logic [47:0] STEP_WORD,
    input wire logic [47:0] ACCUMULATOR,
    input wire logic [15:0] PHASE_WORD
);
    import dtwp_pkg::*;
    // Single domain, so one clock and one reset
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // Parked in holdover for three samples
    sequence s_hold3;
        (LOOP_MODE == DTWP_HOLDOVER) [*3];
    endsequence
    // Quiet bus, so the phase offset is settled
    sequence s_no_write;
        !$past(REG_WE) && !$past(REG_WE, 2) && !$past(REG_WE, 3);
    endsequence
    a_accum_adds_step: assert property (ACCUMULATOR == $past(ACCUMULATOR) + $past(STEP_WORD))
        else $error("accumulator did not add step word");
    a_phase_tracks_accum: assert property (s_no_write |-> PHASE_WORD - $past(PHASE_WORD) ==
        $past(ACCUMULATOR[47:32]) - $past(ACCUMULATOR[47:32], 2))
        else $error("phase word does not track accumulator");
    a_closed_loop_word: assert property ($past(LOOP_MODE) == DTWP_CLOSED |-> STEP_WORD == $past(LOOP_STEP_WORD)
        || STEP_WORD[23:0] == 24'h000000 || STEP_WORD[23:0] == 24'hFFFFFF)
        else $error("closed loop step word not taken");
    a_holdover_word_steady: assert property (s_hold3 |=> $stable(STEP_WORD))
        else $error("holdover step word moved");
    a_strobe_one_cycle: assert property (HISTORY_STROBE |=> !HISTORY_STROBE)
        else $error("history strobe longer than one cycle");
    a_flag_set_strobe: assert property (HISTORY_STROBE && $past(HISTORY_IRQ_ENABLE) |-> HISTORY_UPDATED_FLAG)
        else $error("enabled strobe did not set flag");
    a_flag_rise_cause: assert property ($rose(HISTORY_UPDATED_FLAG) |-> HISTORY_STROBE)
        else $error("flag rose without strobe");
    a_valid_rise_cause: assert property ($rose(HISTORY_VALID) |-> HISTORY_STROBE)
        else $error("history valid rose without strobe");
endmodule : dtwp_top_monitor

bind dtwp_top dtwp_top_monitor #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_mon (.CLK(CLK), .RESET_N(RESET_N),
    .REG_WE(REG_WE), .LOOP_MODE(LOOP_MODE), .LOOP_STEP_WORD(LOOP_STEP_WORD),
    .HISTORY_IRQ_ENABLE(HISTORY_IRQ_ENABLE), .HISTORY_STROBE(HISTORY_STROBE),
    .HISTORY_UPDATED_FLAG(HISTORY_UPDATED_FLAG), .HISTORY_VALID(HISTORY_VALID),
    .STEP_WORD(STEP_WORD), .ACCUMULATOR(ACCUMULATOR), .PHASE_WORD(PHASE_WORD));

`default_nettype wire

// file: test/dtwp_loop_model.sv
`timescale 1ns/1ps
`default_nettype none

module dtwp_loop_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [47:0] target,
    output logic [47:0] word
);
    // Filter output settles one sample after the target moves
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            word <= 48'h000000000000;
        end else begin
            word <= target;
        end
    end
endmodule : dtwp_loop_model

`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    import dtwp_pkg::*;
    // Short millisecond keeps history intervals cheap
    localparam int unsigned CPM = 100;
    localparam logic [47:0] W1 = 48'hC00000000005;
    localparam logic [47:0] P1 = 48'h0123456789AB;
    localparam logic [47:0] P2 = 48'h00ABCDEF0123;
    localparam logic [47:0] P3 = 48'h00ABCE000777;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic we = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    dtwp_mode_type mode = DTWP_FREE_RUN;
    logic [47:0] target = 48'h000000000000;
    logic [47:0] loop_word;
    logic rs = 1'b0;
    logic mfp = 1'b0;
    logic ien = 1'b1;
    logic fc = 1'b0;
    logic hs, hf, hv;
    logic [47:0] step, acc, a0, v;
    logic [15:0] phase;
    logic [9:0] fsc;
    int errors = 0;
    int n_tests = 0;
    int t1, t2, t3;

    dtwp_top #(.CYCLES_PER_MS(CPM)) DUT (.CLK(clk), .RESET_N(reset_n), .REG_WE(we), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .LOOP_MODE(mode), .LOOP_STEP_WORD(loop_word),
        .REF_SWITCH(rs), .MFP_CLEAR_HISTORY(mfp), .HISTORY_IRQ_ENABLE(ien), .HISTORY_FLAG_CLEAR(fc),
        .HISTORY_STROBE(hs), .HISTORY_UPDATED_FLAG(hf), .HISTORY_VALID(hv), .STEP_WORD(step),
        .ACCUMULATOR(acc), .PHASE_WORD(phase), .FULL_SCALE_CURRENT(fsc));
    dtwp_loop_model u_loop (.clk(clk), .reset_n(reset_n), .target(target), .word(loop_word));

    // Free-running sample clock
    always #5 clk = ~clk;

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    // Byte write, strobe held over one rising edge
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk);
        we = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        we = 1'b0;
    endtask : wr

    // Six bytes, lowest address carries the low byte
    task automatic wr6(input logic [11:0] a, input logic [47:0] d);
        for (int i = 0; i < 6; i++) wr(a + 12'(i), d[8 * i +: 8]);
    endtask : wr6

    // Read data is registered one edge after the address
    task automatic rd6(input logic [11:0] a, output logic [47:0] d);
        for (int i = 0; i < 6; i++) begin
            @(negedge clk);
            addr = a + 12'(i);
            @(negedge clk);
            d[8 * i +: 8] = rdata;
        end
    endtask : rd6

    // Bounded wait for the next history strobe
    task automatic wstrobe(output int t);
        for (int k = 0; k < 1000; k++) begin
            @(negedge clk);
            if (hs === 1'b1) break;
        end
        chk({47'h0, hs}, 48'h000000000001);
        t = int'($time / 10);
    endtask : wstrobe

    task automatic stop_test;
        if (errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    initial begin
        cyc(10);
        reset_n = 1'b1;
        rd6(12'h307, v);
        chk(v, 48'hFFFFFF000000);
        rd6(12'h318, v);
        chk(v, 48'h000000000001);
        wr(12'hD14, 8'hAA);
        rd6(12'hD14, v);
        chk(v, 48'h000000000000);
        wr(12'h213, 8'hFF);
        wr(12'h214, 8'h03);
        cyc(2);
        chk({38'h0, fsc}, 48'h0000000003FF);
        wr(12'h319, 8'h01);
        wr6(12'h300, W1);
        cyc(2);
        chk(step, W1);
        a0 = acc;
        cyc(1);
        chk(acc, a0 + W1);
        wr(12'h30D, 8'h34);
        wr(12'h30E, 8'h12);
        cyc(3);
        a0 = acc;
        cyc(1);
        chk({32'h0, phase}, {32'h0, a0[47:32] + 16'h1234});
        target = P1;
        mode = DTWP_CLOSED;
        cyc(3);
        chk(step, P1);
        wr6(12'h307, {24'h010000, 24'h008000});
        cyc(3);
        chk(step, 48'h010000FFFFFF);
        target = 48'h000100000000;
        cyc(3);
        chk(step, 48'h008000000000);
        wr6(12'h307, 48'hFFFFFF000000);
        mode = DTWP_HOLDOVER;
        cyc(3);
        chk(step, W1);
        mode = DTWP_FREE_RUN;
        wr(12'h31B, 8'h10);
        target = P1;
        mode = DTWP_CLOSED;
        cyc(3);
        mode = DTWP_HOLDOVER;
        cyc(3);
        chk(step, P1);
        mode = DTWP_FREE_RUN;
        wr(12'h318, 8'h02);
        wr(12'h319, 8'h00);
        wr(12'h31B, 8'h01);
        wr(12'hA03, 8'h04);
        target = P2;
        cyc(2);
        mode = DTWP_CLOSED;
        wstrobe(t1);
        chk({46'h0, hv, hf}, 48'h000000000003);
        rd6(12'hD14, v);
        chk(v, P2);
        wstrobe(t2);
        chk(48'(t2 - t1), 48'(CPM));
        target = P3;
        fc = 1'b1;
        ien = 1'b0;
        cyc(1);
        fc = 1'b0;
        chk({47'h0, hf}, 48'h000000000000);
        wstrobe(t3);
        chk(48'(t3 - t2), 48'(2 * CPM));
        chk({47'h0, hf}, 48'h000000000000);
        rd6(12'hD14, v);
        chk(v, P3);
        mode = DTWP_HOLDOVER;
        cyc(3);
        chk(step, P3);
        wr(12'h31B, 8'h08);
        rs = 1'b1;
        cyc(1);
        rs = 1'b0;
        cyc(2);
        chk({47'h0, hv}, 48'h000000000001);
        mfp = 1'b1;
        cyc(8);
        chk({47'h0, hv}, 48'h000000000000);
        rd6(12'hD14, v);
        chk(v, 48'h000000000000);
        // Fresh history, then a switch without persistence drops it
        mode = DTWP_CLOSED;
        wstrobe(t1);
        chk({47'h0, hv}, 48'h000000000001);
        wr(12'h31B, 8'h00);
        rs = 1'b1;
        cyc(1);
        rs = 1'b0;
        cyc(2);
        chk({47'h0, hv}, 48'h000000000000);
        rd6(12'hD14, v);
        chk(v, 48'h000000000000);
        stop_test();
    end

    // Cuts a hang well past the expected run length
    initial begin
        #(20000 * 10);
        errors++;
        stop_test();
    end
endmodule : tb

`default_nettype wire
